// >>> design/rcp_fifo.sv
/*
  Flip-flop FIFO with valid/ready on both sides and registered full and
  empty. Assumes the single system clock and synchronous reset.
*/
`default_nettype none
module rcp_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  rcp_stream_if.snk wr,
  rcp_stream_if.src rd
);
  import rcp_pkg::*;
  localparam int unsigned AW = $clog2(D);

  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q;
  logic full_q, empty_q, push, pop;
  logic [AW:0] cnt_d;

  // =====================================================
  // handshakes; full and empty are flops so ready/valid are clean
  assign push = wr.valid & ~full_q;
  assign pop = rd.ready & ~empty_q;
  assign wr.ready = ~full_q;
  assign rd.valid = ~empty_q;
  assign rd.data = mem_q[rp_q];
  assign cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);

  // storage, written at the write index
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_q[wp_q] <= wr.data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      full_q <= 1'b0;
      empty_q <= 1'b1;
    end
    else
    begin
      if (push)
      begin
        wp_q <= (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
      end
      if (pop)
      begin
        rp_q <= (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_d;
      full_q <= (cnt_d == (AW + 1)'(D));
      empty_q <= (cnt_d == '0);
    end
  end

  chk_fifo_no_overrun: assert property (@(posedge clk) disable iff (sys_rst)
    full_q |-> cnt_q == (AW + 1)'(D)) else $error("fifo full flag without full count");
endmodule
`default_nettype wire

// >>> design/rcp_parser.sv
/*
  Remote command parser: takes characters from a serial port or a
  parallel instrument bus, splits lines into commands and hands each
  one, classified, to the executor, save the serial remote, local and
  lockout commands, which it acts on itself. Assumes the executor sits on the
  same clock, answers exp_nparam combinationally from cmd_hdr, and
  raises ovl_busy while any overlapped command still runs.
*/
`default_nettype none
module rcp_parser (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic if_sel,
  input wire logic ser_valid,
  input wire logic [7:0] ser_data,
  output logic ser_ready,
  input wire logic bus_valid,
  input wire logic [7:0] bus_data,
  input wire logic bus_atn,
  input wire logic bus_eoi,
  output logic bus_ready,
  input wire logic ren_pin,
  output logic cmd_valid,
  input wire logic cmd_ready,
  output logic [31:0] cmd_hdr,
  output logic cmd_common,
  output logic cmd_query,
  output logic [2:0] cmd_nparam,
  output rcp_pkg::rcp_unit_t cmd_unit,
  output logic [3:0] cmd_scale,
  input wire logic [2:0] exp_nparam,
  output logic cmd_err,
  input wire logic ovl_busy,
  output logic opc_done,
  output logic remote,
  output logic lockout
);
  import rcp_pkg::*;

  rcp_stream_if #(.W(FIFO_W)) fin ();
  rcp_stream_if #(.W(FIFO_W)) fout ();

  logic stg_v_q, ser_rdy_q, bus_rdy_q, stg_v_d;
  logic [7:0] stg_q;
  logic ser_take, bus_take, msg_take, txt_take, end_f;
  logic [6:0] raw_c, up_c, c;
  rcp_state_t st_q;
  logic pend_q, any_q, hdr_done_q, com_q, par_empty_q, comma_q, num_q;
  logic null_q, uerr_q, qry_q, err_q, cval_q, opc_pend_q, opc_q;
  logic [2:0] hlen_q, npar_q;
  logic [6:0] hlast_q;
  logic [31:0] hdr_q;
  logic [63:0] unit_q;
  logic [3:0] ulen_q, scale_q;
  rcp_unit_t usel_q, ulook;
  logic pop_ok, take_c, is_sep, is_sp, close_now, absorb, in_hdr, comma;
  logic pchar, numc, pclose, ubad, seg_clr, sonly, bad, is_wai;
  logic ren_s1_q, ren_s2_q, ren_s3_q, ren_q, remote_q, lockout_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // =====================================================
  // input stage: one character held until the buffer takes it
  assign ser_take = ser_valid & ser_rdy_q;
  assign bus_take = bus_valid & bus_rdy_q;
  assign msg_take = bus_take & bus_atn;
  assign txt_take = ser_take | (bus_take & ~bus_atn);
  assign raw_c = if_sel ? bus_data[6:0] : ser_data[6:0];
  assign up_c = (raw_c >= CH_LC_A && raw_c <= CH_LC_Z) ? raw_c - CH_CASE : raw_c;
  assign end_f = (raw_c == CH_CR) | (if_sel ? bus_eoi : (raw_c == CH_LF));
  assign stg_v_d = txt_take | (stg_v_q & ~fin.ready);
  assign fin.valid = stg_v_q;
  assign fin.data = stg_q;

  // ready only with an empty stage, so take and drain never collide
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      stg_v_q <= 1'b0;
      ser_rdy_q <= 1'b0;
      bus_rdy_q <= 1'b0;
    end
    else
    begin
      stg_v_q <= stg_v_d;
      ser_rdy_q <= ~stg_v_d & ~if_sel;
      bus_rdy_q <= ~stg_v_d & if_sel;
    end
  end

  // stage data: end-of-message flag over the folded character
  always_ff @(posedge clk)
  begin
    if (txt_take)
    begin
      stg_q <= {end_f, up_c};
    end
  end

  rcp_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr(fin),
    .rd(fout)
  );

  // =====================================================
  // character decode; popping stops outside run so the buffer fills
  assign pop_ok = (st_q == P_RUN) & ~pend_q;
  assign fout.ready = pop_ok;
  assign take_c = fout.valid & pop_ok;
  assign c = fout.data[6:0];
  assign is_sep = (c == CH_SEMI) | (c == CH_CR) | (c == CH_LF);
  assign is_sp = (c == CH_SPACE) | (c == CH_TAB);
  assign close_now = (st_q == P_RUN) & (pend_q | (take_c & is_sep));
  assign absorb = take_c & ~is_sep & ~is_sp;
  assign in_hdr = ~hdr_done_q;
  assign comma = absorb & ~in_hdr & (c == CH_COMMA);
  assign pchar = absorb & ~in_hdr & ~comma;
  assign numc = ((c >= CH_D0) && (c <= CH_D9)) | (c == CH_PLUS) | (c == CH_MINUS)
              | (c == CH_DOT) | ((c == CH_EXP) & num_q);
  assign pclose = comma | (close_now & any_q);
  assign ulook = unit_lookup(unit_q);
  assign ubad = num_q & (ulen_q != '0) & ((ulen_q > UNIT_MAX) | (ulook == U_NONE));
  assign sonly = ~com_q & ((hdr_q == HDR_REMO) | (hdr_q == HDR_LOCA) | (hdr_q == HDR_LOCK));
  assign bad = null_q | uerr_q | (npar_q != exp_nparam) | (sonly & if_sel);
  assign is_wai = com_q & (hdr_q == HDR_WAI);
  // segment state is dropped on empty segments, errors, local
  // commands and accepted commands
  assign seg_clr = (close_now & ~any_q) | ((st_q == P_CHK) & (bad | sonly))
                 | ((st_q == P_OUT) & cmd_ready);

  // =====================================================
  // segment collection: header, parameters, unit suffix
  always_ff @(posedge clk)
  begin
    if (sys_rst || seg_clr)
    begin
      any_q <= 1'b0;
      hdr_done_q <= 1'b0;
      com_q <= 1'b0;
      hlen_q <= '0;
      hdr_q <= '0;
      hlast_q <= '0;
      npar_q <= '0;
      par_empty_q <= 1'b1;
      comma_q <= 1'b0;
      num_q <= 1'b0;
      null_q <= 1'b0;
      uerr_q <= 1'b0;
      unit_q <= '0;
      ulen_q <= '0;
      usel_q <= U_NONE;
      scale_q <= '0;
    end
    else
    begin
      if (absorb)
      begin
        any_q <= 1'b1;
      end
      if (absorb & in_hdr)
      begin
        if (~any_q && c == CH_STAR)
        begin
          com_q <= 1'b1;
        end
        if (hlen_q != HDR_KEEP)
        begin
          hdr_q <= {hdr_q[23:0], 1'b0, c};
          hlen_q <= hlen_q + 1'b1;
        end
        hlast_q <= c;
      end
      if (take_c & is_sp & any_q)
      begin
        hdr_done_q <= 1'b1;
      end
      if (comma)
      begin
        comma_q <= 1'b1;
        if (par_empty_q)
        begin
          null_q <= 1'b1;
        end
      end
      if (close_now & any_q & comma_q & par_empty_q)
      begin
        null_q <= 1'b1; // trailing comma is a null parameter
      end
      if (pchar)
      begin
        if (par_empty_q)
        begin
          par_empty_q <= 1'b0;
          comma_q <= 1'b0;
          npar_q <= (npar_q == 3'h7) ? npar_q : npar_q + 1'b1;
        end
        if (numc && ulen_q == '0)
        begin
          num_q <= 1'b1;
        end
        else
        begin
          unit_q <= {unit_q[55:0], 1'b0, c};
          ulen_q <= (ulen_q > UNIT_MAX) ? ulen_q : ulen_q + 1'b1;
        end
      end
      if (pclose)
      begin
        if (ubad)
        begin
          uerr_q <= 1'b1;
        end
        else if (num_q && ulen_q != '0)
        begin
          usel_q <= ulook;
          scale_q <= unit_scale(ulook);
        end
        unit_q <= '0;
        ulen_q <= '0;
        num_q <= 1'b0;
        par_empty_q <= 1'b1;
      end
    end
  end

  // =====================================================
  // sequencer: one command at a time, in line order
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_q <= P_RUN;
      pend_q <= 1'b0;
      cval_q <= 1'b0;
      err_q <= 1'b0;
      qry_q <= 1'b0;
    end
    else
    begin
      err_q <= 1'b0;
      unique case (st_q)
        P_RUN:
        begin
          // a character carrying the end flag closes after it is kept
          pend_q <= take_c & ~is_sep & fout.data[7];
          if (close_now & any_q)
          begin
            st_q <= P_CHK;
          end
        end
        P_CHK:
        begin
          if (bad)
          begin
            err_q <= 1'b1;
            st_q <= P_RUN;
          end
          else if (sonly)
          begin
            st_q <= P_RUN;
          end
          else
          begin
            qry_q <= (hlast_q == CH_QUERY);
            cval_q <= 1'b1;
            st_q <= P_OUT;
          end
        end
        P_OUT:
        begin
          // held until the executor takes it; overlapped work does
          // not stall here, only the wait command does
          if (cmd_ready)
          begin
            cval_q <= 1'b0;
            st_q <= is_wai ? P_WAIT : P_RUN;
          end
        end
        P_WAIT:
        begin
          if (~ovl_busy)
          begin
            st_q <= P_RUN;
          end
        end
      endcase
    end
  end

  // =====================================================
  // operation complete: one pulse once overlapped work drains
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      opc_pend_q <= 1'b0;
      opc_q <= 1'b0;
    end
    else
    begin
      opc_q <= opc_pend_q & ~ovl_busy;
      if ((st_q == P_OUT) && cmd_ready && com_q && hdr_q == HDR_OPC)
      begin
        opc_pend_q <= 1'b1; // a new request wins over the clear
      end
      else if (~ovl_busy)
      begin
        opc_pend_q <= 1'b0;
      end
    end
  end

  // =====================================================
  // remote state: REN and bus messages, or serial text commands
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ren_s1_q <= 1'b0;
      ren_s2_q <= 1'b0;
      ren_s3_q <= 1'b0;
      ren_q <= 1'b0;
    end
    else
    begin
      ren_s1_q <= ren_pin;
      ren_s2_q <= ren_s1_q;
      ren_s3_q <= ren_s2_q;
      if (ren_s2_q == ren_s3_q)
      begin
        ren_q <= ren_s3_q; // glitch shorter than a clock is ignored
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      remote_q <= 1'b0;
      lockout_q <= 1'b0;
    end
    else if (if_sel)
    begin
      if ((ren_s2_q == ren_s3_q) && ren_s3_q && !ren_q)
      begin
        remote_q <= 1'b1;
      end
      else if ((ren_s2_q == ren_s3_q) && !ren_s3_q && ren_q)
      begin
        remote_q <= 1'b0;
        lockout_q <= 1'b0;
      end
      else if (msg_take && bus_data[6:0] == MSG_GTL)
      begin
        remote_q <= 1'b0;
      end
      else if (msg_take && bus_data[6:0] == MSG_LLO)
      begin
        lockout_q <= 1'b1;
      end
    end
    else if ((st_q == P_CHK) && !bad && sonly)
    begin
      remote_q <= (hdr_q == HDR_REMO) ? 1'b1 : (hdr_q == HDR_LOCA) ? 1'b0 : remote_q;
      lockout_q <= lockout_q | (hdr_q == HDR_LOCK);
    end
  end

  // =====================================================
  // outputs, all straight from flops
  assign ser_ready = ser_rdy_q;
  assign bus_ready = bus_rdy_q;
  assign cmd_valid = cval_q;
  assign cmd_hdr = hdr_q;
  assign cmd_common = com_q;
  assign cmd_query = qry_q;
  assign cmd_nparam = npar_q;
  assign cmd_unit = usel_q;
  assign cmd_scale = scale_q;
  assign cmd_err = err_q;
  assign opc_done = opc_q;
  assign remote = remote_q;
  assign lockout = lockout_q;

  // =====================================================
  // checks
  chk_case_fold: assert property (ser_take && ser_data[6:0] >= CH_LC_A
    && ser_data[6:0] <= CH_LC_Z |=> stg_q[6:0] == $past(ser_data[6:0]) - CH_CASE)
    else $error("lower case character not folded");
  chk_msb_drop: assert property (ser_take && ser_data[7] && ser_data[6:0] != CH_CR
    && ser_data[6:0] != CH_LF
    |=> !stg_q[7] && (stg_q[6:0] | CH_CASE) == ($past(ser_data[6:0]) | CH_CASE))
    else $error("serial data bit 7 leaked into the stream");
  chk_atn_filter: assert property (msg_take |=> !stg_v_q)
    else $error("attention byte entered the command stream");
  chk_wai_hold: assert property (st_q == P_WAIT && ovl_busy |=> st_q == P_WAIT && !cval_q)
    else $error("wait released while overlapped work pending");
  chk_opc_done: assert property (opc_pend_q && !ovl_busy |=> opc_q ##1 !opc_q)
    else $error("operation complete not reported");
  chk_empty_seg: assert property (close_now && !any_q |=> st_q == P_RUN && !cval_q)
    else $error("empty segment issued");
  chk_bad_unit: assert property (st_q == P_CHK && uerr_q |=> err_q && !cval_q)
    else $error("bad unit not rejected");
  chk_nparam_err: assert property (st_q == P_CHK && npar_q != exp_nparam
    |=> err_q ##1 !err_q) else $error("parameter count error missed");
  chk_cmd_hold: assert property (cval_q && !cmd_ready |=> cval_q && $stable(hdr_q))
    else $error("command dropped before acceptance");
  chk_query_flag: assert property (st_q == P_CHK && !bad && !sonly
    |=> cval_q && qry_q == ($past(hlast_q) == CH_QUERY))
    else $error("query flag wrong");
endmodule
`default_nettype wire

// >>> design/rcp_pkg.sv
/*
  Shared constants and types for the remote command parser: character
  codes, header keys, buffer sizes, parser states and unit codes.
  Assumes that all users import the whole package.
*/
`default_nettype none
package rcp_pkg;
  // =====================================================
  // buffer shape
  localparam int unsigned FIFO_W = 8;
  localparam int unsigned FIFO_D = 8;

  // =====================================================
  // character codes, 7-bit ascii
  localparam logic [6:0] CH_CR = 7'h0D;
  localparam logic [6:0] CH_LF = 7'h0A;
  localparam logic [6:0] CH_TAB = 7'h09;
  localparam logic [6:0] CH_SPACE = 7'h20;
  localparam logic [6:0] CH_SEMI = 7'h3B;
  localparam logic [6:0] CH_STAR = 7'h2A;
  localparam logic [6:0] CH_QUERY = 7'h3F;
  localparam logic [6:0] CH_COMMA = 7'h2C;
  localparam logic [6:0] CH_PLUS = 7'h2B;
  localparam logic [6:0] CH_MINUS = 7'h2D;
  localparam logic [6:0] CH_DOT = 7'h2E;
  localparam logic [6:0] CH_D0 = 7'h30;
  localparam logic [6:0] CH_D9 = 7'h39;
  localparam logic [6:0] CH_EXP = 7'h45;
  localparam logic [6:0] CH_LC_A = 7'h61;
  localparam logic [6:0] CH_LC_Z = 7'h7A;
  localparam logic [6:0] CH_CASE = 7'h20;

  // =====================================================
  // bus interface messages carried with attention true
  localparam logic [6:0] MSG_GTL = 7'h01;
  localparam logic [6:0] MSG_LLO = 7'h11;

  // =====================================================
  // first four header characters, right aligned, 8 bits each
  localparam logic [31:0] HDR_WAI = 32'h2A57_4149;
  localparam logic [31:0] HDR_OPC = 32'h2A4F_5043;
  localparam logic [31:0] HDR_REMO = 32'h5245_4D4F;
  localparam logic [31:0] HDR_LOCA = 32'h4C4F_4341;
  localparam logic [31:0] HDR_LOCK = 32'h4C4F_434B;
  localparam logic [2:0] HDR_KEEP = 3'h4;
  localparam logic [3:0] UNIT_MAX = 4'h8;

  // =====================================================
  // parser states, gray along run-check-issue-wait
  typedef enum logic [1:0] {
    P_RUN = 2'h0,
    P_CHK = 2'h1,
    P_OUT = 2'h3,
    P_WAIT = 2'h2
  } rcp_state_t;

  typedef enum logic [4:0] {
    U_NONE, U_UV, U_MV, U_V, U_KV, U_UA, U_MA, U_A, U_OHM, U_KOHM, U_MOHM,
    U_CEL, U_FAR, U_PSI, U_MMHG, U_INHG, U_INH2O4C, U_INH2O20C, U_INH2O60F,
    U_CMH2O4C, U_CMH2O20C, U_MMH2O4C, U_MMH2O20C, U_BAR, U_MBAR, U_KPA,
    U_MPA, U_KGCM2
  } rcp_unit_t;

  // upper-case suffix, right aligned, 8 bits per character
  function automatic rcp_unit_t unit_lookup(input logic [63:0] s);
    unique case (s)
      64'h0000_0000_0000_5556: return U_UV;
      64'h0000_0000_0000_4D56: return U_MV;
      64'h0000_0000_0000_0056: return U_V;
      64'h0000_0000_0000_4B56: return U_KV;
      64'h0000_0000_0000_5541: return U_UA;
      64'h0000_0000_0000_4D41: return U_MA;
      64'h0000_0000_0000_0041: return U_A;
      64'h0000_0000_004F_484D: return U_OHM;
      64'h0000_0000_4B4F_484D: return U_KOHM;
      64'h0000_0000_4D4F_484D: return U_MOHM;
      64'h0000_0000_0043_454C: return U_CEL;
      64'h0000_0000_0046_4152: return U_FAR;
      64'h0000_0000_0050_5349: return U_PSI;
      64'h0000_0000_4D4D_4847: return U_MMHG;
      64'h0000_0000_494E_4847: return U_INHG;
      64'h0049_4E48_324F_3443: return U_INH2O4C;
      64'h494E_4832_4F32_3043: return U_INH2O20C;
      64'h494E_4832_4F36_3046: return U_INH2O60F;
      64'h0043_4D48_324F_3443: return U_CMH2O4C;
      64'h434D_4832_4F32_3043: return U_CMH2O20C;
      64'h004D_4D48_324F_3443: return U_MMH2O4C;
      64'h4D4D_4832_4F32_3043: return U_MMH2O20C;
      64'h0000_0000_0042_4152: return U_BAR;
      64'h0000_0000_4D42_4152: return U_MBAR;
      64'h0000_0000_004B_5041: return U_KPA;
      64'h0000_0000_004D_5041: return U_MPA;
      64'h0000_4B47_2F43_4D32: return U_KGCM2;
      default: return U_NONE;
    endcase
  endfunction

  // decimal exponent that a suffix applies to the number
  function automatic logic [3:0] unit_scale(input rcp_unit_t u);
    unique case (u)
      U_UV, U_UA: return 4'hA;
      U_MV, U_MA, U_MBAR: return 4'hD;
      U_KV, U_KOHM, U_KPA: return 4'h3;
      U_MOHM, U_MPA: return 4'h6;
      default: return 4'h0;
    endcase
  endfunction
endpackage
`default_nettype wire

// >>> design/rcp_stream_if.sv
/*
  Valid/ready character stream between the parser front end, its
  buffer and the parser proper. Assumes one clock for both ends.
*/
`default_nettype none
interface rcp_stream_if #(parameter int unsigned W = 8) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> tb/rcp_host_model.sv
/*
  Host computer model: sends byte strings to the parser's serial or bus
  side and drives the REN line. Assumes the parser's clock.
*/
`default_nettype none
module rcp_host_model (
  input wire logic clk,
  input wire logic ser_ready,
  input wire logic bus_ready,
  output logic ser_valid,
  output logic [7:0] ser_data,
  output logic bus_valid,
  output logic [7:0] bus_data,
  output logic bus_atn,
  output logic bus_eoi,
  output logic ren_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic stuck = 1'b0;

  // =====
  // idle lines at time zero
  initial
  begin
    ser_valid = 1'b0;
    ser_data = 8'h00;
    bus_valid = 1'b0;
    bus_data = 8'h00;
    bus_atn = 1'b0;
    bus_eoi = 1'b0;
    ren_pin = 1'b0;
  end

  // offer one byte; atn marks a bus management byte
  task automatic put(input logic bus, input logic [7:0] b, input logic atn, input logic eoi);
    if (bus)
    begin
      bus_valid <= 1'b1;
      bus_data <= b;
      bus_atn <= atn;
      bus_eoi <= eoi;
    end
    else
    begin
      ser_valid <= 1'b1;
      ser_data <= b;
    end
  endtask

  // release inverts data so a stale byte never looks fresh
  task automatic drop;
    ser_valid <= 1'b0;
    bus_valid <= 1'b0;
    ser_data <= ~ser_data;
    bus_data <= ~bus_data;
    bus_atn <= ~bus_atn;
    bus_eoi <= ~bus_eoi;
  endtask

  // whole string; the next byte is loaded at the edge that takes one
  task automatic send(input logic bus, input string s, input logic atn, input logic eoi);
    int i;
    int n;
    stuck = 1'b0;
    @(posedge clk);
    put(bus, s[0], atn, eoi && s.len() == 1);
    for (i = 0; i < s.len(); i++)
    begin
      for (n = 0; n < 200; n++)
      begin
        @(posedge clk);
        if ((bus ? bus_ready : ser_ready) === 1'b1)
          break;
      end
      if (n == 200)
        stuck = 1'b1;
      if (i + 1 < s.len() && n < 200)
        put(bus, s[i+1], atn, eoi && i + 2 == s.len());
      else
      begin
        drop();
        break;
      end
    end
  endtask

  // REN level for the bus remote state
  task automatic set_ren(input logic v);
    @(posedge clk);
    ren_pin <= v;
  endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
/*
  Self-checking bench for rcp_parser: the host model sends lines and
  the bench plays the executor. Assumes one 25 MHz clock.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import rcp_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic if_sel = 1'b0;
  logic cmd_ready = 1'b0;
  logic ovl_busy = 1'b0;
  logic ser_valid, ser_ready, bus_valid, bus_atn, bus_eoi, bus_ready, ren_pin;
  logic cmd_valid, cmd_common, cmd_query, cmd_err, opc_done, remote, lockout;
  logic [7:0] ser_data, bus_data;
  logic [31:0] cmd_hdr;
  logic [2:0] cmd_nparam, exp_nparam;
  logic [3:0] cmd_scale;
  rcp_unit_t cmd_unit;
  int n_errors = 0;
  int tests_run = 0;
  string units [27] = '{"uv", "mv", "v", "kv", "ua", "ma", "a", "ohm", "kohm", "mohm",
    "cel", "far", "psi", "mmhg", "inhg", "inh2o4c", "inh2o20c", "inh2o60f", "cmh2o4c",
    "cmh2o20c", "mmh2o4c", "mmh2o20c", "bar", "mbar", "kpa", "mpa", "kg/cm2"};

  always #20 clk = ~clk;
  // executor table: only the output command takes a parameter
  assign exp_nparam = (cmd_hdr === 32'h004F_5554) ? 3'h1 : 3'h0;

  rcp_parser uut (.clk(clk), .sys_rst(sys_rst), .if_sel(if_sel), .ser_valid(ser_valid),
    .ser_data(ser_data), .ser_ready(ser_ready), .bus_valid(bus_valid), .bus_data(bus_data),
    .bus_atn(bus_atn), .bus_eoi(bus_eoi), .bus_ready(bus_ready), .ren_pin(ren_pin),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_hdr(cmd_hdr), .cmd_common(cmd_common),
    .cmd_query(cmd_query), .cmd_nparam(cmd_nparam), .cmd_unit(cmd_unit),
    .cmd_scale(cmd_scale), .exp_nparam(exp_nparam), .cmd_err(cmd_err),
    .ovl_busy(ovl_busy), .opc_done(opc_done), .remote(remote), .lockout(lockout));
  rcp_host_model host (.clk(clk), .ser_ready(ser_ready), .bus_ready(bus_ready),
    .ser_valid(ser_valid), .ser_data(ser_data), .bus_valid(bus_valid), .bus_data(bus_data),
    .bus_atn(bus_atn), .bus_eoi(bus_eoi), .ren_pin(ren_pin));

  // =====
  // shared checks and waits; every wait is bounded
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic tx(input logic bus, input string s, input logic atn, input logic eoi);
    host.send(bus, s, atn, eoi);
    check("host byte taken", 32'h0, 32'(host.stuck));
    if (host.stuck)
      wrap_up();
  endtask

  task automatic wait_out(output logic e);
    int i;
    for (i = 0; i < 300; i++)
    begin
      @(posedge clk);
      #1;
      if (cmd_valid === 1'b1 || cmd_err === 1'b1)
        break;
    end
    check("command out", 32'h1, 32'(i < 300));
    if (i == 300)
      wrap_up();
    e = cmd_err;
  endtask

  task automatic await_lvl(input string what, ref logic sig, input logic v);
    int i;
    for (i = 0; i < 60; i++)
    begin
      @(posedge clk);
      #1;
      if (sig === v)
        break;
    end
    check(what, 32'(v), 32'(sig));
    if (sig !== v)
      wrap_up();
  endtask

  // fields while valid, then one cycle of accept
  task automatic expect_cmd(input logic [31:0] hdr, input logic cm, input logic q,
    input logic [2:0] np, input rcp_unit_t u, input logic [3:0] sc);
    logic e;
    wait_out(e);
    check("cmd_err", 32'h0, 32'(e));
    check("cmd_hdr", hdr, cmd_hdr);
    check("cmd flags", 32'({cm, q, np}), 32'({cmd_common, cmd_query, cmd_nparam}));
    check("cmd_unit", 32'(u), 32'(cmd_unit));
    check("cmd_scale", 32'(sc), 32'(cmd_scale));
    @(posedge clk) cmd_ready <= 1'b1;
    @(posedge clk) cmd_ready <= 1'b0;
  endtask

  task automatic expect_err;
    logic e;
    wait_out(e);
    check("cmd_err", 32'h1, 32'(e));
  endtask

  function automatic logic [3:0] scale_of(input int k);
    case (k)
      0, 4: return 4'hA;
      1, 5, 23: return 4'hD;
      3, 8, 24: return 4'h3;
      9, 25: return 4'h6;
      default: return 4'h0;
    endcase
  endfunction

  // =====
  // scenarios
  task automatic t_text;
    fork
      tx(1'b0, "*\357pc?\015out 1 zz\012out\015out ,1\015", 1'b0, 1'b0);
      begin
        expect_cmd(HDR_OPC, 1'b1, 1'b1, 3'h0, U_NONE, 4'h0);
        await_lvl("opc_done", opc_done, 1'b1);
        expect_err();
        expect_err();
        expect_err();
      end
    join
    $display("test text done");
  endtask

  task automatic t_units;
    int k;
    for (k = 0; k < 27; k++)
      fork
        tx(1'b0, {"out 1 ", units[k], "\015"}, 1'b0, 1'b0);
        expect_cmd(32'h004F_5554, 1'b0, 1'b0, 3'h1, rcp_unit_t'(k + 1), scale_of(k));
      join
    $display("test units done");
  endtask

  // busy executor: first command still issued, wait holds the last
  task automatic t_overlap;
    int i;
    int hits;
    hits = 0;
    @(posedge clk) ovl_busy <= 1'b1;
    fork
      tx(1'b0, "oper;;*wai;oper;\015", 1'b0, 1'b0);
      begin
        expect_cmd(32'h4F50_4552, 1'b0, 1'b0, 3'h0, U_NONE, 4'h0);
        expect_cmd(HDR_WAI, 1'b1, 1'b0, 3'h0, U_NONE, 4'h0);
        for (i = 0; i < 20; i++)
        begin
          @(posedge clk);
          #1;
          if (cmd_valid === 1'b1)
            hits++;
        end
        check("hold after wait", 32'h0, 32'(hits));
        @(posedge clk) ovl_busy <= 1'b0;
        expect_cmd(32'h4F50_4552, 1'b0, 1'b0, 3'h0, U_NONE, 4'h0);
      end
    join
    $display("test overlap done");
  endtask

  task automatic t_modes;
    fork
      tx(1'b0, "remote\015lockout\015local\015", 1'b0, 1'b0);
      begin
        await_lvl("remote", remote, 1'b1);
        await_lvl("lockout", lockout, 1'b1);
        await_lvl("remote", remote, 1'b0);
      end
    join
    $display("test serial modes done");
  endtask

  task automatic t_bus;
    // mid-run reset drops the lockout left by the serial test
    @(posedge clk) sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    check("reset state", 32'h0, 32'({remote, lockout, cmd_valid}));
    sys_rst <= 1'b0;
    if_sel <= 1'b1;
    host.set_ren(1'b1);
    await_lvl("remote", remote, 1'b1);
    fork
      begin
        tx(1'b1, "\021", 1'b1, 1'b0);
        tx(1'b1, "\001", 1'b1, 1'b0);
        tx(1'b1, "X", 1'b1, 1'b0);
        tx(1'b1, "*opc?", 1'b0, 1'b1);
        tx(1'b1, "remote\015", 1'b0, 1'b0);
      end
      begin
        await_lvl("lockout", lockout, 1'b1);
        await_lvl("remote", remote, 1'b0);
        expect_cmd(HDR_OPC, 1'b1, 1'b1, 3'h0, U_NONE, 4'h0);
        expect_err();
        check("bus remote text", 32'h0, 32'(remote));
      end
    join
    host.set_ren(1'b0);
    await_lvl("lockout", lockout, 1'b0);
    $display("test bus done");
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    t_text();
    t_units();
    t_overlap();
    t_modes();
    t_bus();
    wrap_up();
  end
endmodule
`default_nettype wire
